/* File: common/pdc_pkg.sv */
// Package for the power detector configuration and flag block.
// Assumes a byte-wide register port and one 50 MHz clock standing for fs/8.
package pdc_pkg;
	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_FLT0_FMT   = 8'h13;
	localparam logic [7:0] ADDR_FLT1_FMT   = 8'h1A;
	localparam logic [7:0] ADDR_DWELL_LO   = 8'h1D;
	localparam logic [7:0] ADDR_DWELL_HI   = 8'h1E;
	localparam logic [7:0] ADDR_PWR_EN     = 8'h20;
	localparam logic [7:0] ADDR_PWR_EXP    = 8'h21;
	localparam logic [7:0] ADDR_PWR_HI_LO  = 8'h22;
	localparam logic [7:0] ADDR_PWR_HI_HI  = 8'h23;
	localparam logic [7:0] ADDR_PWR_LO_LO  = 8'h24;
	localparam logic [7:0] ADDR_PWR_LO_HI  = 8'h25;
	localparam logic [7:0] ADDR_F0_UP_LO   = 8'h0F;
	localparam logic [7:0] ADDR_F0_UP_HI   = 8'h10;
	localparam logic [7:0] ADDR_F0_DN_LO   = 8'h11;
	localparam logic [7:0] ADDR_F0_DN_HI   = 8'h12;
	localparam logic [7:0] ADDR_F1_UP_LO   = 8'h16;
	localparam logic [7:0] ADDR_F1_UP_HI   = 8'h17;
	localparam logic [7:0] ADDR_F1_DN_LO   = 8'h18;
	localparam logic [7:0] ADDR_F1_DN_HI   = 8'h19;
	localparam logic [7:0] ADDR_IRQ_STAT   = 8'h40;
	localparam logic [7:0] ADDR_IRQ_MASK   = 8'h41;
	localparam logic [7:0] ADDR_FLAG_STAT  = 8'h42;
	// ------------------------------------------------------------------
	// Fields and reset values
	// ------------------------------------------------------------------
	localparam int          FMT_BIT        = 0;
	localparam int          PWR_EN_BIT     = 0;
	localparam int          EXP_W          = 5;
	localparam logic [4:0]  EXP_MAX        = 5'h10;
	localparam logic [7:0]  RST_BYTE       = 8'h00;
	localparam logic [15:0] FULL_SCALE     = 16'h4000;
	localparam int          IRQ_W          = 4;
	// Interrupt status bits.
	localparam int IRQ_F0_SET = 0;
	localparam int IRQ_F1_SET = 1;
	localparam int IRQ_PWR_HI = 2;
	localparam int IRQ_PWR_LO = 3;
endpackage

/* File: design/pdc_flag.sv */
// One filter peak comparator with a dwell-qualified release.
// Assumes signed 2.14 samples arrive one per clock on the fs/8 clock.
module pdc_flag (
	// Clock and reset.
	input  wire logic               i_clk,
	input  wire logic               i_rst_n,
	// Configuration.
	input  wire logic signed [15:0] i_upper,
	input  wire logic signed [15:0] i_lower,
	input  wire logic        [15:0] i_hold,
	input  wire logic               i_wide,
	// Sample and flag.
	input  wire logic signed [15:0] i_sample,
	output logic             [1:0]  o_flag,
	output logic                    o_set_pulse
);
	logic        flag_reg;
	logic        low_reg;
	logic [15:0] cnt_reg;
	wire         above   = i_sample > i_upper;
	wire         below   = i_sample < i_lower;
	wire         done    = (cnt_reg >= i_hold);

	// Flag sets on crossing and releases only after an unbroken dwell below.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			flag_reg    <= 1'b0;
			low_reg     <= 1'b0;
			cnt_reg     <= 16'h0000;
			o_set_pulse <= 1'b0;
		end else begin
			o_set_pulse <= above && !flag_reg;
			if (above) begin
				flag_reg <= 1'b1;
				cnt_reg  <= 16'h0000;
			end else if (!below) begin
				cnt_reg  <= 16'h0000;
			end else if (flag_reg) begin
				if (done)
					flag_reg <= 1'b0;
				else
					cnt_reg  <= cnt_reg + 16'h0001;
			end
			low_reg <= below;
		end
	end

	// Wide format adds a second bit showing the output sits below the lower limit.
	assign o_flag = i_wide ? {low_reg, flag_reg} : {1'b0, flag_reg};
endmodule

/* File: design/pdc_rms.sv */
// Average power accumulator over a block of 2^M clocks, M capped at 16, with two limit compares.
// Assumes power samples are unsigned fractions of full power, one per clock.
module pdc_rms (
	// Clock and reset.
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	// Configuration.
	input  wire logic        i_on,
	input  wire logic [4:0]  i_exp,
	input  wire logic [15:0] i_upper,
	input  wire logic [15:0] i_lower,
	// Data and results.
	input  wire logic [15:0] i_power,
	output logic      [15:0] o_avg,
	output logic             o_high,
	output logic             o_low,
	output logic             o_done
);
	logic [32:0] acc_reg;
	logic [16:0] cnt_reg;
	wire  [4:0]  expo  = (i_exp > pdc_pkg::EXP_MAX) ? pdc_pkg::EXP_MAX : i_exp;
	wire  [16:0] last  = (17'h00001 << expo) - 17'h00001;
	wire  [32:0] sum   = acc_reg + {17'h00000, i_power};
	wire  [32:0] shf   = sum >> expo;
	wire  [15:0] avg   = shf[15:0];

	// Accumulate for a block, then latch the average and compare.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			acc_reg <= 33'h000000000;
			cnt_reg <= 17'h00000;
			o_avg   <= 16'h0000;
			o_high  <= 1'b0;
			o_low   <= 1'b0;
			o_done  <= 1'b0;
		end else if (!i_on) begin
			acc_reg <= 33'h000000000;
			cnt_reg <= 17'h00000;
			o_high  <= 1'b0;
			o_low   <= 1'b0;
			o_done  <= 1'b0;
		end else begin
			o_done <= (cnt_reg == last);
			if (cnt_reg == last) begin
				acc_reg <= 33'h000000000;
				cnt_reg <= 17'h00000;
				o_avg   <= avg;
				o_high  <= avg > i_upper;
				o_low   <= avg < i_lower;
			end else begin
				acc_reg <= sum;
				cnt_reg <= cnt_reg + 17'h00001;
			end
		end
	end
endmodule

/* File: design/pdc_top.sv */
// Top of the power detector configuration and flag block.
// Assumes i_clk is the fs/8 clock and that register port signals are synchronous.
//
// How it works
// - Bit 0 picks one- or two-bit format.
// - Filter above upper limit sets flag.
// - Flag clears after unbroken dwell below lower.
// - Dwell is sixteen-bit count, two bytes.
// - Enable bit gates the average power detector.
// - Block length is two to the M; the code caps M at 16.
// - Average compared against upper and lower limits.
// - Filter limits are signed 2.14 values.
module pdc_top (
	// Clock and reset.
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	// Register port.
	input  wire logic [7:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [7:0]  o_rdata,
	// Detector data.
	input  wire logic [15:0] i_filt0,
	input  wire logic [15:0] i_filt1,
	input  wire logic [15:0] i_power,
	// Results.
	output logic      [1:0]  o_filt0_flag,
	output logic      [1:0]  o_filt1_flag,
	output logic             o_pwr_high,
	output logic             o_pwr_low,
	output logic             o_irq
);
	// ------------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------------
	logic        first_filter_wide_output_reg;
	logic        second_filter_wide_output_reg;
	logic [15:0] filter_flag_hold_count_reg;
	logic        average_power_detect_on_reg;
	logic [4:0]  average_power_block_exp_reg;
	logic [15:0] average_power_upper_limit_reg;
	logic [15:0] average_power_lower_limit_reg;
	logic [15:0] first_filter_upper_limit_reg;
	logic [15:0] first_filter_lower_limit_reg;
	logic [15:0] second_filter_upper_limit_reg;
	logic [15:0] second_filter_lower_limit_reg;
	logic [3:0]  irq_stat_reg;
	logic [3:0]  irq_mask_reg;
	logic [3:0]  irq_stat_next;
	logic [7:0]  rdata_next;
	logic [3:0]  events;
	logic        f0_set;
	logic        f1_set;
	logic        pwr_done;
	logic        pwr_hi_d;
	logic        pwr_lo_d;

	// Write decodes per address.
	wire wr_f0fmt  = i_wr && (i_addr == pdc_pkg::ADDR_FLT0_FMT);
	wire wr_f1fmt  = i_wr && (i_addr == pdc_pkg::ADDR_FLT1_FMT);
	wire wr_dwl    = i_wr && (i_addr == pdc_pkg::ADDR_DWELL_LO);
	wire wr_dwh    = i_wr && (i_addr == pdc_pkg::ADDR_DWELL_HI);
	wire wr_pen    = i_wr && (i_addr == pdc_pkg::ADDR_PWR_EN);
	wire wr_pexp   = i_wr && (i_addr == pdc_pkg::ADDR_PWR_EXP);
	wire wr_phl    = i_wr && (i_addr == pdc_pkg::ADDR_PWR_HI_LO);
	wire wr_phh    = i_wr && (i_addr == pdc_pkg::ADDR_PWR_HI_HI);
	wire wr_pll    = i_wr && (i_addr == pdc_pkg::ADDR_PWR_LO_LO);
	wire wr_plh    = i_wr && (i_addr == pdc_pkg::ADDR_PWR_LO_HI);
	wire wr_0ul    = i_wr && (i_addr == pdc_pkg::ADDR_F0_UP_LO);
	wire wr_0uh    = i_wr && (i_addr == pdc_pkg::ADDR_F0_UP_HI);
	wire wr_0dl    = i_wr && (i_addr == pdc_pkg::ADDR_F0_DN_LO);
	wire wr_0dh    = i_wr && (i_addr == pdc_pkg::ADDR_F0_DN_HI);
	wire wr_1ul    = i_wr && (i_addr == pdc_pkg::ADDR_F1_UP_LO);
	wire wr_1uh    = i_wr && (i_addr == pdc_pkg::ADDR_F1_UP_HI);
	wire wr_1dl    = i_wr && (i_addr == pdc_pkg::ADDR_F1_DN_LO);
	wire wr_1dh    = i_wr && (i_addr == pdc_pkg::ADDR_F1_DN_HI);
	wire wr_istat  = i_wr && (i_addr == pdc_pkg::ADDR_IRQ_STAT);
	wire wr_imask  = i_wr && (i_addr == pdc_pkg::ADDR_IRQ_MASK);

	// Registers of one to five bits; unused upper bits are dropped on write.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			first_filter_wide_output_reg  <= 1'b0;
			second_filter_wide_output_reg <= 1'b0;
			average_power_detect_on_reg   <= 1'b0;
			average_power_block_exp_reg   <= 5'h00;
			irq_mask_reg                  <= 4'h0;
		end else begin
			if (wr_f0fmt)
				first_filter_wide_output_reg <= i_wdata[pdc_pkg::FMT_BIT];
			if (wr_f1fmt)
				second_filter_wide_output_reg <= i_wdata[pdc_pkg::FMT_BIT];
			if (wr_pen)
				average_power_detect_on_reg <= i_wdata[pdc_pkg::PWR_EN_BIT];
			if (wr_pexp)
				average_power_block_exp_reg <= i_wdata[pdc_pkg::EXP_W-1:0];
			if (wr_imask)
				irq_mask_reg <= i_wdata[3:0];
		end
	end

	// Sixteen-bit values split over two byte addresses.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			filter_flag_hold_count_reg    <= {pdc_pkg::RST_BYTE, pdc_pkg::RST_BYTE};
			average_power_upper_limit_reg <= {pdc_pkg::RST_BYTE, pdc_pkg::RST_BYTE};
			average_power_lower_limit_reg <= {pdc_pkg::RST_BYTE, pdc_pkg::RST_BYTE};
			first_filter_upper_limit_reg  <= {pdc_pkg::RST_BYTE, pdc_pkg::RST_BYTE};
			first_filter_lower_limit_reg  <= {pdc_pkg::RST_BYTE, pdc_pkg::RST_BYTE};
			second_filter_upper_limit_reg <= {pdc_pkg::RST_BYTE, pdc_pkg::RST_BYTE};
			second_filter_lower_limit_reg <= {pdc_pkg::RST_BYTE, pdc_pkg::RST_BYTE};
		end else begin
			if (wr_dwl) filter_flag_hold_count_reg[7:0]  <= i_wdata;
			if (wr_dwh) filter_flag_hold_count_reg[15:8] <= i_wdata;
			if (wr_phl) average_power_upper_limit_reg[7:0]  <= i_wdata;
			if (wr_phh) average_power_upper_limit_reg[15:8] <= i_wdata;
			if (wr_pll) average_power_lower_limit_reg[7:0]  <= i_wdata;
			if (wr_plh) average_power_lower_limit_reg[15:8] <= i_wdata;
			if (wr_0ul) first_filter_upper_limit_reg[7:0]   <= i_wdata;
			if (wr_0uh) first_filter_upper_limit_reg[15:8]  <= i_wdata;
			if (wr_0dl) first_filter_lower_limit_reg[7:0]   <= i_wdata;
			if (wr_0dh) first_filter_lower_limit_reg[15:8]  <= i_wdata;
			if (wr_1ul) second_filter_upper_limit_reg[7:0]  <= i_wdata;
			if (wr_1uh) second_filter_upper_limit_reg[15:8] <= i_wdata;
			if (wr_1dl) second_filter_lower_limit_reg[7:0]  <= i_wdata;
			if (wr_1dh) second_filter_lower_limit_reg[15:8] <= i_wdata;
		end
	end

	// ------------------------------------------------------------------
	// Detectors
	// ------------------------------------------------------------------
	pdc_flag u_flag0 (
		.i_clk       (i_clk),
		.i_rst_n     (i_rst_n),
		.i_upper     (first_filter_upper_limit_reg),
		.i_lower     (first_filter_lower_limit_reg),
		.i_hold      (filter_flag_hold_count_reg),
		.i_wide      (first_filter_wide_output_reg),
		.i_sample    (i_filt0),
		.o_flag      (o_filt0_flag),
		.o_set_pulse (f0_set)
	);

	pdc_flag u_flag1 (
		.i_clk       (i_clk),
		.i_rst_n     (i_rst_n),
		.i_upper     (second_filter_upper_limit_reg),
		.i_lower     (second_filter_lower_limit_reg),
		.i_hold      (filter_flag_hold_count_reg),
		.i_wide      (second_filter_wide_output_reg),
		.i_sample    (i_filt1),
		.o_flag      (o_filt1_flag),
		.o_set_pulse (f1_set)
	);

	pdc_rms u_rms (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_on    (average_power_detect_on_reg),
		.i_exp   (average_power_block_exp_reg),
		.i_upper (average_power_upper_limit_reg),
		.i_lower (average_power_lower_limit_reg),
		.i_power (i_power),
		.o_avg   (),
		.o_high  (o_pwr_high),
		.o_low   (o_pwr_low),
		.o_done  (pwr_done)
	);

	// ------------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------------
	// Power events fire when a finished block newly reports a crossing.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pwr_hi_d <= 1'b0;
			pwr_lo_d <= 1'b0;
		end else begin
			pwr_hi_d <= o_pwr_high;
			pwr_lo_d <= o_pwr_low;
		end
	end

	assign events = {o_pwr_low && !pwr_lo_d, o_pwr_high && !pwr_hi_d, f1_set, f0_set};

	// A new event wins over a write-one-to-clear in the same cycle.
	assign irq_stat_next = (irq_stat_reg & ~(wr_istat ? i_wdata[3:0] : 4'h0)) | events;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			irq_stat_reg <= 4'h0;
		else
			irq_stat_reg <= irq_stat_next;
	end

	assign o_irq = |(irq_stat_reg & irq_mask_reg);

	// ------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------
	// Read data is registered and stands only in the cycle after the strobe.
	always_comb begin
		rdata_next = 8'h00;
		if (i_rd) begin
			case (i_addr)
				pdc_pkg::ADDR_FLT0_FMT:  rdata_next = {7'h00, first_filter_wide_output_reg};
				pdc_pkg::ADDR_FLT1_FMT:  rdata_next = {7'h00, second_filter_wide_output_reg};
				pdc_pkg::ADDR_DWELL_LO:  rdata_next = filter_flag_hold_count_reg[7:0];
				pdc_pkg::ADDR_DWELL_HI:  rdata_next = filter_flag_hold_count_reg[15:8];
				pdc_pkg::ADDR_PWR_EN:    rdata_next = {7'h00, average_power_detect_on_reg};
				pdc_pkg::ADDR_PWR_EXP:   rdata_next = {3'h0, average_power_block_exp_reg};
				pdc_pkg::ADDR_PWR_HI_LO: rdata_next = average_power_upper_limit_reg[7:0];
				pdc_pkg::ADDR_PWR_HI_HI: rdata_next = average_power_upper_limit_reg[15:8];
				pdc_pkg::ADDR_PWR_LO_LO: rdata_next = average_power_lower_limit_reg[7:0];
				pdc_pkg::ADDR_PWR_LO_HI: rdata_next = average_power_lower_limit_reg[15:8];
				pdc_pkg::ADDR_F0_UP_LO:  rdata_next = first_filter_upper_limit_reg[7:0];
				pdc_pkg::ADDR_F0_UP_HI:  rdata_next = first_filter_upper_limit_reg[15:8];
				pdc_pkg::ADDR_F0_DN_LO:  rdata_next = first_filter_lower_limit_reg[7:0];
				pdc_pkg::ADDR_F0_DN_HI:  rdata_next = first_filter_lower_limit_reg[15:8];
				pdc_pkg::ADDR_F1_UP_LO:  rdata_next = second_filter_upper_limit_reg[7:0];
				pdc_pkg::ADDR_F1_UP_HI:  rdata_next = second_filter_upper_limit_reg[15:8];
				pdc_pkg::ADDR_F1_DN_LO:  rdata_next = second_filter_lower_limit_reg[7:0];
				pdc_pkg::ADDR_F1_DN_HI:  rdata_next = second_filter_lower_limit_reg[15:8];
				pdc_pkg::ADDR_IRQ_STAT:  rdata_next = {4'h0, irq_stat_reg};
				pdc_pkg::ADDR_IRQ_MASK:  rdata_next = {4'h0, irq_mask_reg};
				pdc_pkg::ADDR_FLAG_STAT: rdata_next = {o_pwr_low, o_pwr_high, pwr_done, 1'b0,
					o_filt1_flag, o_filt0_flag};
				default:                 rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			o_rdata <= 8'h00;
		else
			o_rdata <= rdata_next;
	end
endmodule

/* File: verif/pdc_top_sva.sv */
// Checker for the power detector configuration and flag block.
// Assumes it is bound to pdc_top and sees only that module's ports.
module pdc_top_sva (
	// Clock and reset.
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	// Register port.
	input  wire logic [7:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic [7:0]  o_rdata,
	// Detector data and results.
	input  wire logic [15:0] i_filt0,
	input  wire logic [15:0] i_filt1,
	input  wire logic [15:0] i_power,
	input  wire logic [1:0]  o_filt0_flag,
	input  wire logic [1:0]  o_filt1_flag,
	input  wire logic        o_pwr_high,
	input  wire logic        o_pwr_low,
	input  wire logic        o_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        fmt0;
	logic        pwr_on;
	logic        fmt_wr;
	logic [15:0] up0;
	logic [15:0] lo0;
	// -----------------------------------------------------------------
	// Shadow settings
	// -----------------------------------------------------------------
	// Shadows update on the same edge as the design, so compares line up.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fmt0   <= 1'b0;
			pwr_on <= 1'b0;
			up0    <= 16'h0000;
			lo0    <= 16'h0000;
		end else if (i_wr) begin
			case (i_addr)
				pdc_pkg::ADDR_FLT0_FMT: fmt0 <= i_wdata[0];
				pdc_pkg::ADDR_PWR_EN:   pwr_on <= i_wdata[0];
				pdc_pkg::ADDR_F0_UP_LO: up0[7:0] <= i_wdata;
				pdc_pkg::ADDR_F0_UP_HI: up0[15:8] <= i_wdata;
				pdc_pkg::ADDR_F0_DN_LO: lo0[7:0] <= i_wdata;
				pdc_pkg::ADDR_F0_DN_HI: lo0[15:8] <= i_wdata;
				default: ;
			endcase
		end
	end
	// A format write may change the wide bit on the next cycle.
	assign fmt_wr = i_wr && (i_addr == pdc_pkg::ADDR_FLT0_FMT);
	// -----------------------------------------------------------------
	// Properties
	// -----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	fmt_read_a: assert property (i_rd && i_addr == pdc_pkg::ADDR_FLT0_FMT |=>
		o_rdata[7:1] == 7'h00) else $error("format register upper bits not zero");
	en_read_a: assert property (i_rd && i_addr == pdc_pkg::ADDR_PWR_EN |=>
		o_rdata[7:1] == 7'h00) else $error("enable register upper bits not zero");
	exp_read_a: assert property (i_rd && i_addr == pdc_pkg::ADDR_PWR_EXP |=>
		o_rdata[7:5] == 3'h0) else $error("block length upper bits not zero");
	dwell_back_a: assert property (i_wr && i_addr == pdc_pkg::ADDR_DWELL_LO ##1 !i_wr
		##1 i_rd && i_addr == pdc_pkg::ADDR_DWELL_LO |=> o_rdata == $past(i_wdata, 3))
		else $error("dwell low byte read back wrong");
	flag_set_a: assert property ($signed(i_filt0) > $signed(up0) |=> o_filt0_flag[0])
		else $error("flag not set above upper limit");
	flag_keep_a: assert property (o_filt0_flag[0] && !($signed(i_filt0) < $signed(lo0))
		|=> o_filt0_flag[0]) else $error("flag cleared without dwell below lower");
	wide_below_a: assert property (fmt0 && !fmt_wr && $signed(i_filt0) < $signed(lo0)
		|=> o_filt0_flag[1]) else $error("wide format below bit missing");
	narrow_fmt_a: assert property (!fmt0 && !fmt_wr |=> !o_filt0_flag[1])
		else $error("narrow format shows second bit");
	rms_off_a: assert property (!pwr_on [*2] |-> !o_pwr_high && !o_pwr_low)
		else $error("power flags active while detector off");
	flag_rise_c: cover property ($rose(o_filt0_flag[0]));
	flag_fall_c: cover property ($fell(o_filt0_flag[0]));
	pwr_high_c: cover property ($rose(o_pwr_high));
	irq_rise_c: cover property ($rose(o_irq));
endmodule

bind pdc_top pdc_top_sva pdc_top_sva_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_filt0(i_filt0),
	.i_filt1(i_filt1), .i_power(i_power), .o_filt0_flag(o_filt0_flag),
	.o_filt1_flag(o_filt1_flag), .o_pwr_high(o_pwr_high), .o_pwr_low(o_pwr_low), .o_irq(o_irq));

/* File: verif/test_pdc_top.sv */
// Self-checking testbench for the power detector configuration block.
// Assumes one 50 MHz clock and a strobe register port with read data a cycle later.
module test_pdc_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_clk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic [7:0]  i_addr = 8'h00;
	logic [7:0]  i_wdata = 8'h00;
	logic        i_wr = 1'b0;
	logic        i_rd = 1'b0;
	logic [15:0] i_filt0 = 16'h0000;
	logic [15:0] i_filt1 = 16'h0000;
	logic [15:0] i_power = 16'h0000;
	logic [7:0]  o_rdata;
	logic [1:0]  o_filt0_flag;
	logic [1:0]  o_filt1_flag;
	logic        o_pwr_high;
	logic        o_pwr_low;
	logic        o_irq;
	int          error_cnt = 0;
	int          compares = 0;
	logic [7:0]  ta[7] = '{8'h13, 8'h1A, 8'h20, 8'h21, 8'h1D, 8'h1E, 8'h50};
	logic [7:0]  td[7] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hA5, 8'h5A, 8'hFF};
	logic [7:0]  te[7] = '{8'h01, 8'h01, 8'h01, 8'h1F, 8'hA5, 8'h5A, 8'h00};
	// -----------------------------------------------------------------
	// Clock, design and checks
	// -----------------------------------------------------------------
	always #10 i_clk = ~i_clk;
	pdc_top pdc_top_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_filt0(i_filt0), .i_filt1(i_filt1),
		.i_power(i_power), .o_filt0_flag(o_filt0_flag), .o_filt1_flag(o_filt1_flag),
		.o_pwr_high(o_pwr_high), .o_pwr_low(o_pwr_low), .o_irq(o_irq));
	// Compare one observed value against its expectation.
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Print the verdict and stop.
	task automatic summarize;
		if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Every task starts on a fresh edge, so no strobe is driven twice in one step.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 check({8'h00, o_rdata}, {8'h00, exp});
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	// Drive both filter samples, then let n edges see them.
	task automatic fdrv(input logic [15:0] a, input logic [15:0] b, input int n);
		@(posedge i_clk);
		i_filt0 <= a;
		i_filt1 <= b;
		step(n);
	endtask
	// Cut a hang short.
	initial begin
		repeat (20000) @(posedge i_clk);
		error_cnt++;
		summarize();
	end
	// -----------------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------------
	initial begin
		repeat (16) @(posedge i_clk);
		i_rst_n <= 1'b1;
		foreach (ta[k]) rd(ta[k], 8'h00);
		rd(8'h25, 8'h00);
		foreach (ta[k]) begin
			wr(ta[k], td[k]);
			rd(ta[k], te[k]);
		end
		for (int k = 0; k < 4; k++) wr(ta[k], 8'h00);
		// Upper 0x1000, lower 0x0800, dwell of three, first flag unmasked.
		wr(8'h10, 8'h10);
		wr(8'h12, 8'h08);
		wr(8'h1D, 8'h03);
		// The high byte still holds the earlier read-back pattern.
		wr(8'h1E, 8'h00);
		wr(8'h41, 8'h01);
		fdrv(16'h2000, 16'h0000, 1);
		check(o_filt0_flag, 2'b01);
		// The status bit lands one edge after the flag, so wait for it.
		step(1);
		check(o_irq, 1'b1);
		rd(8'h40, 8'h01);
		fdrv(16'h0C00, 16'h0000, 5);
		check(o_filt0_flag, 2'b01);
		// Negative sample is below only under a signed compare.
		fdrv(16'hC000, 16'h0000, 2);
		fdrv(16'h0C00, 16'h0000, 1);
		fdrv(16'hC000, 16'h0000, 3);
		check(o_filt0_flag, 2'b01);
		step(1);
		check(o_filt0_flag, 2'b00);
		wr(8'h40, 8'h01);
		step(1);
		check(o_irq, 1'b0);
		// Both filters wide; second filter uses its reset limits of zero.
		wr(8'h41, 8'h00);
		wr(8'h13, 8'h01);
		wr(8'h1A, 8'h01);
		fdrv(16'h2000, 16'h2000, 1);
		check(o_filt0_flag, 2'b01);
		check(o_filt1_flag, 2'b01);
		check(o_irq, 1'b0);
		rd(8'h40, 8'h03);
		wr(8'h41, 8'h02);
		step(1);
		check(o_irq, 1'b1);
		wr(8'h40, 8'h03);
		step(1);
		check(o_irq, 1'b0);
		fdrv(16'hC000, 16'hC000, 5);
		check(o_filt0_flag, 2'b10);
		check(o_filt1_flag, 2'b10);
		wr(8'h13, 8'h00);
		wr(8'h1A, 8'h00);
		step(2);
		check(o_filt0_flag, 2'b00);
		check(o_filt1_flag, 2'b00);
		// Average 0x2001 lies just above 0x2000 and just below 0x2002.
		wr(8'h23, 8'h20);
		i_power <= 16'h2001;
		wr(8'h22, 8'h00);
		wr(8'h24, 8'h02);
		wr(8'h25, 8'h20);
		wr(8'h21, 8'h02);
		wr(8'h41, 8'h0C);
		step(8);
		check({o_pwr_high, o_pwr_low}, 2'b00);
		wr(8'h20, 8'h01);
		step(12);
		check({o_pwr_high, o_pwr_low}, 2'b11);
		check(o_irq, 1'b1);
		wr(8'h20, 8'h00);
		step(2);
		check({o_pwr_high, o_pwr_low}, 2'b00);
		summarize();
	end
endmodule
